// *** logic/dmsr_defines.svh ***
// offsets, field values and word constants of the drive monitor register bank
// assumes the serial frame decoder presents 16-bit register addresses
`ifndef DMSR_DEFINES_SVH
`define DMSR_DEFINES_SVH

// register addresses
`define DMSR_ADDR_DIGITAL_OUTPUT_STATE 16'h2211
`define DMSR_ADDR_ACTIVE_STEP_SPEED 16'h2212
`define DMSR_ADDR_INPUT_PIN_STATE 16'h2213
`define DMSR_ADDR_OUTPUT_PIN_STATE 16'h2214
`define DMSR_ADDR_ACTUAL_REVOLUTION_COUNT 16'h2215
`define DMSR_ADDR_PULSE_INPUT_FREQUENCY 16'h2216
`define DMSR_ADDR_PULSE_INPUT_POSITION 16'h2217
`define DMSR_ADDR_POSITION_TRACKING_ERROR 16'h2218
`define DMSR_ADDR_COUNTER_OVERLOAD_LEVEL 16'h2219
`define DMSR_ADDR_GROUND_FAULT_LEVEL 16'h221A
`define DMSR_ADDR_BUS_VOLTAGE_RIPPLE 16'h221B
`define DMSR_ADDR_LOGIC_REGISTER_MIRROR 16'h221C
`define DMSR_ADDR_MAGNET_MOTOR_POLES 16'h221D
`define DMSR_ADDR_USER_PAGE_VALUE 16'h221E
`define DMSR_ADDR_SELECTED_OUTPUT_VALUE 16'h221F
`define DMSR_ADDR_RUN_TURN_COUNT 16'h2220
`define DMSR_ADDR_RUN_POSITION 16'h2221
`define DMSR_ADDR_FAN_SPEED_PERCENT 16'h2222
`define DMSR_ADDR_CONTROL_MODE_STATE 16'h2223
`define DMSR_ADDR_SWITCHING_FREQUENCY 16'h2224
`define DMSR_ADDR_RESERVED_SLOT 16'h2225
`define DMSR_ADDR_DRIVE_STATUS_WORD 16'h2226
`define DMSR_ADDR_ESTIMATED_TORQUE 16'h2227
`define DMSR_ADDR_TORQUE_SETPOINT 16'h2228
`define DMSR_ADDR_ENERGY_READING 16'h2229
`define DMSR_ADDR_PULSE_TERMINAL_COUNT_LOW 16'h222A
`define DMSR_ADDR_PULSE_TERMINAL_COUNT_HIGH 16'h222B
`define DMSR_ADDR_MOTOR_POSITION_LOW 16'h222C
`define DMSR_ADDR_MOTOR_POSITION_HIGH 16'h222D
`define DMSR_ADDR_LOOP_REFERENCE 16'h222E
`define DMSR_ADDR_LOOP_OFFSET 16'h222F
`define DMSR_ADDR_LOOP_OUTPUT_FREQUENCY 16'h2230
`define DMSR_ADDR_HARDWARE_IDENTITY 16'h2231
`define DMSR_ADDR_AUXILIARY_FREQUENCY 16'h2232
`define DMSR_ADDR_PRIMARY_FREQUENCY 16'h2233
`define DMSR_ADDR_COMBINED_FREQUENCY 16'h2234

// drive status word field values, position step codes, control mode values and word constants
`define DMSR_DIR_NONE 2'h0
`define DMSR_DIR_FORWARD 2'h1
`define DMSR_DIR_REVERSE 2'h2
`define DMSR_READY_OK 2'h1
`define DMSR_READY_ERROR 2'h2
`define DMSR_READY_NONE 2'h0
`define DMSR_STEP_NONE 2'h0
`define DMSR_STEP_UP 2'h1
`define DMSR_STEP_DOWN 2'h2
`define DMSR_MODE_SPEED 16'h0000
`define DMSR_MODE_TORQUE 16'h0001
`define DMSR_COUNT_MAX 16'hFFFF
`define DMSR_WORD_ZERO 16'h0000

`endif

// *** logic/dmsr_pkg.sv ***
// types of the drive monitor register bank
// assumes the header of constants is compiled alongside
package dmsr_pkg;

    // live values supplied by the drive core, same clock
    typedef struct packed {
        logic [15:0] digital_output_state;
        logic [15:0] active_step_speed;
        logic [15:0] input_pin_state;
        logic [15:0] output_pin_state;
        logic [15:0] pulse_input_frequency;
        logic [15:0] position_tracking_error;
        logic [15:0] counter_overload_level;
        logic [15:0] ground_fault_level;
        logic [15:0] bus_voltage_ripple;
        logic [15:0] logic_controller_word;
        logic [15:0] magnet_motor_poles;
        logic [15:0] user_page_value;
        logic [15:0] selected_output_value;
        logic [15:0] fan_speed_percent;
        logic [15:0] switching_frequency;
        logic [15:0] estimated_torque;
        logic [15:0] torque_setpoint;
        logic [15:0] energy_reading;
        logic [15:0] loop_reference;
        logic [15:0] loop_offset;
        logic [15:0] loop_output_frequency;
        logic [15:0] auxiliary_frequency;
        logic [15:0] primary_frequency;
        logic [15:0] combined_frequency;
        logic running;
        logic dir_forward;
        logic dir_reverse;
        logic ready;
        logic fault;
        logic output_on;
        logic alarm;
        logic torque_mode;
        logic stop_display_zero;
    } dmsr_mon_t;

    // one-cycle count events from the drive core
    typedef struct packed {
        logic first_encoder_input;
        logic second_encoder_input;
        logic pulse_capable_input_terminal;
        logic turn_pulse;
        logic position_up;
        logic position_down;
    } dmsr_evt_t;

    // the whole state of the bank
    typedef struct packed {
        logic [15:0] rev_count;
        logic [15:0] pos2_count;
        logic [31:0] term_count;
        logic [15:0] turn_count;
        logic [15:0] run_pos;
        logic [31:0] motor_pos;
        logic [1:0] last_dir;
        logic was_running;
        logic [15:0] rd_data;
        logic ack;
        logic err;
    } dmsr_state_t;

endpackage : dmsr_pkg

// *** logic/dmsr_bank.sv ***
// drive monitor and status register bank, read by the serial link master
// assumes frame decoding is done outside; one register access per request
`timescale 1ns/1ps
`include "dmsr_defines.svh"

module dmsr_bank #(
    parameter logic [15:0] HW_IDENTITY = 16'h0A5C // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire dmsr_pkg::dmsr_mon_t mon,
    input wire dmsr_pkg::dmsr_evt_t evt,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [15:0] addr,
    output logic [15:0] rd_data,
    output logic ack,
    output logic err
);
    import dmsr_pkg::*;

    dmsr_state_t st;
    dmsr_state_t next_st;
    logic [1:0] cur_dir;
    logic [1:0] ready_field;
    logic [15:0] status_word;
    logic [15:0] read_word;
    logic read_hit;
    logic run_start;
    logic [1:0] pos_move;

    // saturating increment for 16-bit counters
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        if (v == `DMSR_COUNT_MAX)
        begin
            return v;
        end
        return v + 16'h0001;
    endfunction : sat_inc

    // operation begins: running now, stopped on the cycle before
    function automatic logic run_begins(input logic now_on, input logic before_on);
        return now_on && !before_on;
    endfunction : run_begins

    // net position move of one cycle; up and down together cancel
    function automatic logic [1:0] pos_step(input dmsr_evt_t e);
        if (e.position_up && !e.position_down)
        begin
            return `DMSR_STEP_UP;
        end
        else if (e.position_down && !e.position_up)
        begin
            return `DMSR_STEP_DOWN;
        end
        return `DMSR_STEP_NONE;
    endfunction : pos_step

    // direction changed straight between forward and reverse
    function automatic logic dir_flipped(input logic [1:0] now_d, input logic [1:0] old_d);
        return (now_d != `DMSR_DIR_NONE) && (old_d != `DMSR_DIR_NONE)
            && (now_d != old_d);
    endfunction : dir_flipped

    // shared decodes of the counter updates
    assign run_start = run_begins(mon.running, st.was_running);
    assign pos_move = pos_step(evt);

    // direction and ready fields from the drive core flags
    always_comb
    begin
        // direction encoding
        // forward wins when the core flags both directions
        if (mon.dir_forward)
        begin
            cur_dir = `DMSR_DIR_FORWARD;
        end
        else if (mon.dir_reverse)
        begin
            cur_dir = `DMSR_DIR_REVERSE;
        end
        else
        begin
            cur_dir = `DMSR_DIR_NONE;
        end
        if (mon.fault)
        begin
            ready_field = `DMSR_READY_ERROR;
        end
        else if (mon.ready)
        begin
            ready_field = `DMSR_READY_OK;
        end
        else
        begin
            ready_field = `DMSR_READY_NONE;
        end
    end

    // packed drive status word
    // output and alarm bits
    assign status_word = {10'h000, mon.alarm, mon.output_on, ready_field, cur_dir};

    // register decode for reads
    always_comb
    begin
        read_hit = 1'b1;
        read_word = `DMSR_WORD_ZERO;
        // unmapped addresses answer zero and raise err
        if (addr == `DMSR_ADDR_DIGITAL_OUTPUT_STATE)
        begin
            read_word = mon.digital_output_state;
        end
        else if (addr == `DMSR_ADDR_ACTIVE_STEP_SPEED)
        begin
            read_word = mon.active_step_speed;
        end
        else if (addr == `DMSR_ADDR_INPUT_PIN_STATE)
        begin
            read_word = mon.input_pin_state;
        end
        else if (addr == `DMSR_ADDR_OUTPUT_PIN_STATE)
        begin
            read_word = mon.output_pin_state;
        end
        else if (addr == `DMSR_ADDR_ACTUAL_REVOLUTION_COUNT)
        begin
            read_word = st.rev_count;
        end
        else if (addr == `DMSR_ADDR_PULSE_INPUT_FREQUENCY)
        begin
            read_word = mon.pulse_input_frequency;
        end
        else if (addr == `DMSR_ADDR_PULSE_INPUT_POSITION)
        begin
            read_word = st.pos2_count;
        end
        else if (addr == `DMSR_ADDR_POSITION_TRACKING_ERROR)
        begin
            read_word = mon.position_tracking_error;
        end
        else if (addr == `DMSR_ADDR_COUNTER_OVERLOAD_LEVEL)
        begin
            read_word = mon.counter_overload_level;
        end
        else if (addr == `DMSR_ADDR_GROUND_FAULT_LEVEL)
        begin
            read_word = mon.ground_fault_level;
        end
        else if (addr == `DMSR_ADDR_BUS_VOLTAGE_RIPPLE)
        begin
            read_word = mon.bus_voltage_ripple;
        end
        else if (addr == `DMSR_ADDR_LOGIC_REGISTER_MIRROR)
        begin
            read_word = mon.logic_controller_word;
        end
        else if (addr == `DMSR_ADDR_MAGNET_MOTOR_POLES)
        begin
            read_word = mon.magnet_motor_poles;
        end
        else if (addr == `DMSR_ADDR_USER_PAGE_VALUE)
        begin
            read_word = mon.user_page_value;
        end
        else if (addr == `DMSR_ADDR_SELECTED_OUTPUT_VALUE)
        begin
            read_word = mon.selected_output_value;
        end
        else if (addr == `DMSR_ADDR_RUN_TURN_COUNT)
        begin
            read_word = st.turn_count;
        end
        else if (addr == `DMSR_ADDR_RUN_POSITION)
        begin
            read_word = st.run_pos;
        end
        else if (addr == `DMSR_ADDR_FAN_SPEED_PERCENT)
        begin
            read_word = mon.fan_speed_percent;
        end
        else if (addr == `DMSR_ADDR_CONTROL_MODE_STATE)
        begin
            read_word = mon.torque_mode ? `DMSR_MODE_TORQUE : `DMSR_MODE_SPEED;
        end
        else if (addr == `DMSR_ADDR_SWITCHING_FREQUENCY)
        begin
            read_word = mon.switching_frequency;
        end
        else if (addr == `DMSR_ADDR_RESERVED_SLOT)
        begin
            read_word = `DMSR_WORD_ZERO; // reserved reads zero
        end
        else if (addr == `DMSR_ADDR_DRIVE_STATUS_WORD)
        begin
            read_word = status_word;
        end
        else if (addr == `DMSR_ADDR_ESTIMATED_TORQUE)
        begin
            read_word = mon.estimated_torque;
        end
        else if (addr == `DMSR_ADDR_TORQUE_SETPOINT)
        begin
            read_word = mon.torque_setpoint;
        end
        else if (addr == `DMSR_ADDR_ENERGY_READING)
        begin
            read_word = mon.energy_reading;
        end
        else if (addr == `DMSR_ADDR_PULSE_TERMINAL_COUNT_LOW)
        begin
            read_word = st.term_count[15:0];
        end
        else if (addr == `DMSR_ADDR_PULSE_TERMINAL_COUNT_HIGH)
        begin
            read_word = st.term_count[31:16];
        end
        else if (addr == `DMSR_ADDR_MOTOR_POSITION_LOW)
        begin
            read_word = st.motor_pos[15:0];
        end
        else if (addr == `DMSR_ADDR_MOTOR_POSITION_HIGH)
        begin
            read_word = st.motor_pos[31:16];
        end
        else if (addr == `DMSR_ADDR_LOOP_REFERENCE)
        begin
            read_word = mon.loop_reference;
        end
        else if (addr == `DMSR_ADDR_LOOP_OFFSET)
        begin
            read_word = mon.loop_offset;
        end
        else if (addr == `DMSR_ADDR_LOOP_OUTPUT_FREQUENCY)
        begin
            read_word = mon.loop_output_frequency;
        end
        else if (addr == `DMSR_ADDR_HARDWARE_IDENTITY)
        begin
            read_word = HW_IDENTITY;
        end
        else if (addr == `DMSR_ADDR_AUXILIARY_FREQUENCY)
        begin
            read_word = mon.auxiliary_frequency;
        end
        else if (addr == `DMSR_ADDR_PRIMARY_FREQUENCY)
        begin
            read_word = mon.primary_frequency;
        end
        else if (addr == `DMSR_ADDR_COMBINED_FREQUENCY)
        begin
            read_word = mon.combined_frequency;
        end
        else
        begin
            read_hit = 1'b0; // unmapped address
        end
    end

    // counters and answer, next state
    always_comb
    begin
        next_st = st;
        next_st.last_dir = cur_dir;
        next_st.was_running = mon.running;
        // revolution restart and saturation
        // a restart wins over a revolution pulse arriving in the same cycle
        if (dir_flipped(cur_dir, st.last_dir))
        begin
            next_st.rev_count = `DMSR_WORD_ZERO;
        end
        else if (!mon.running && mon.stop_display_zero)
        begin
            next_st.rev_count = `DMSR_WORD_ZERO;
        end
        else if (evt.first_encoder_input)
        begin
            next_st.rev_count = sat_inc(st.rev_count);
        end
        if (evt.second_encoder_input)
        begin
            next_st.pos2_count = sat_inc(st.pos2_count);
        end
        // free running terminal pulse count
        // the two halves are read apart, so a carry between reads can tear
        if (evt.pulse_capable_input_terminal)
        begin
            next_st.term_count = st.term_count + 32'h0000_0001;
        end
        if (pos_move == `DMSR_STEP_UP)
        begin
            next_st.motor_pos = st.motor_pos + 32'h0000_0001;
        end
        else if (pos_move == `DMSR_STEP_DOWN)
        begin
            next_st.motor_pos = st.motor_pos - 32'h0000_0001;
        end
        // turn count clear at start, hold when stopped
        // no limit is set for turns, so the count wraps
        if (run_start)
        begin
            next_st.turn_count = `DMSR_WORD_ZERO;
        end
        else if (mon.running && evt.turn_pulse)
        begin
            next_st.turn_count = st.turn_count + 16'h0001;
        end
        // run position clear at start, hold when stopped
        if (run_start)
        begin
            next_st.run_pos = `DMSR_WORD_ZERO;
        end
        else if (mon.running && pos_move == `DMSR_STEP_UP)
        begin
            next_st.run_pos = st.run_pos + 16'h0001;
        end
        else if (mon.running && pos_move == `DMSR_STEP_DOWN)
        begin
            next_st.run_pos = st.run_pos - 16'h0001;
        end
        // writes refused, reads answered next cycle
        // both strobes together count as a refused write
        next_st.ack = rd_req || wr_req;
        next_st.err = wr_req || (rd_req && !read_hit);
        if (rd_req && !wr_req && read_hit)
        begin
            next_st.rd_data = read_word;
        end
        else
        begin
            next_st.rd_data = `DMSR_WORD_ZERO;
        end
    end

    // state register
    // synchronous reset clears every count and the answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign rd_data = st.rd_data;
    assign ack = st.ack;
    assign err = st.err;

endmodule : dmsr_bank

// *** tb/dmsr_bank_chk.sv ***
// checker of the drive monitor register bank, ports of the bank only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "dmsr_defines.svh"

module dmsr_bank_chk (
    input wire logic clk,
    input wire logic rst,
    input wire dmsr_pkg::dmsr_mon_t mon,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [15:0] addr,
    input wire logic [15:0] rd_data,
    input wire logic ack,
    input wire logic err
);
    import dmsr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // plain read and status word read
    logic rd_only;
    assign rd_only = rd_req && !wr_req;
    logic rd_stat;
    assign rd_stat = rd_only && addr == `DMSR_ADDR_DRIVE_STATUS_WORD;

    property p_ack;
        (rd_req || wr_req) |=> ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer to request");
    property p_idle;
        !(rd_req || wr_req) |=> !ack && rd_data == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_wr;
        wr_req |=> err && rd_data == 16'h0000;
    endproperty
    a_wr: assert property (p_wr) else $error("write not refused");
    property p_step;
        rd_only && addr == `DMSR_ADDR_ACTIVE_STEP_SPEED
        |=> !err && rd_data == $past(mon.active_step_speed);
    endproperty
    a_step: assert property (p_step) else $error("step speed read wrong");
    property p_dir;
        rd_stat |=> rd_data[1:0] == ($past(mon.dir_forward) ? 2'h1 :
            $past(mon.dir_reverse) ? 2'h2 : 2'h0);
    endproperty
    a_dir: assert property (p_dir) else $error("direction field wrong");
    property p_ready;
        rd_stat |=> rd_data[3:2] == ($past(mon.fault) ? 2'h2 :
            $past(mon.ready) ? 2'h1 : 2'h0);
    endproperty
    a_ready: assert property (p_ready) else $error("ready field wrong");
    property p_flags;
        rd_stat |=> rd_data[15:4] == {10'h000, $past(mon.alarm), $past(mon.output_on)};
    endproperty
    a_flags: assert property (p_flags) else $error("output or alarm bit wrong");
    property p_mode;
        rd_only && addr == `DMSR_ADDR_CONTROL_MODE_STATE
        |=> rd_data == {15'h0000, $past(mon.torque_mode)};
    endproperty
    a_mode: assert property (p_mode) else $error("control mode wrong");
endmodule : dmsr_bank_chk

bind dmsr_bank dmsr_bank_chk dmsr_bank_chk_inst (.clk(clk), .rst(rst), .mon(mon),
    .rd_req(rd_req), .wr_req(wr_req), .addr(addr), .rd_data(rd_data), .ack(ack), .err(err));

// *** tb/dmsr_master.sv ***
// serial link master model issuing one register access at a time
// assumes the bank answers one cycle after the request edge
`timescale 1ns/1ps

module dmsr_master (
    input wire logic clk,
    output logic rd_req,
    output logic wr_req,
    output logic [15:0] addr,
    input wire logic [15:0] rd_data,
    input wire logic ack,
    input wire logic err
);
    // idle bus, address shows a junk pattern
    initial
    begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = 16'h5AA5;
    end

    // one request pulse, then take the answer
    // writes only on command
    task access(input int gap, input logic w, input logic [15:0] a,
                output logic [15:0] d, output logic e, output logic k);
        repeat (gap + 1) @(posedge clk);
        #1;
        rd_req = !w;
        wr_req = w;
        addr = a;
        @(posedge clk);
        #1;
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = ~a;
        d = rd_data;
        e = err;
        k = ack;
    endtask : access
endmodule : dmsr_master

// *** tb/tb_top.sv ***
// self-checking bench of the drive monitor register bank
// assumes the master model drives the access port
`timescale 1ns/1ps
`include "dmsr_defines.svh"

module tb_top;
    import dmsr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dmsr_mon_t mon;
    dmsr_evt_t evt;
    logic rd_req;
    logic wr_req;
    logic [15:0] addr;
    logic [15:0] rd_data;
    logic ack;
    logic err;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 32'hff36;
    int n;
    logic [15:0] wa [28] = '{16'h2211, 16'h2212, 16'h2213, 16'h2214, 16'h2216, 16'h2218,
        16'h2219, 16'h221A, 16'h221B, 16'h221C, 16'h221D, 16'h221E, 16'h221F, 16'h2222,
        16'h2223, 16'h2224, 16'h2225, 16'h2226, 16'h2227, 16'h2228, 16'h2229, 16'h222E,
        16'h222F, 16'h2230, 16'h2231, 16'h2232, 16'h2233, 16'h2234};
    logic [15:0] ca [8] = '{16'h2215, 16'h2217, 16'h2220, 16'h2221, 16'h222A,
        16'h222B, 16'h222C, 16'h222D};

    // clock of 10 ns
    always #5 clk = ~clk;

    dmsr_bank #(.HW_IDENTITY(16'h3C5A)) dmsr_bank_inst (.clk(clk), .rst(rst), .mon(mon),
        .evt(evt), .rd_req(rd_req), .wr_req(wr_req), .addr(addr), .rd_data(rd_data),
        .ack(ack), .err(err));
    dmsr_master dmsr_master_inst (.clk(clk), .rd_req(rd_req), .wr_req(wr_req),
        .addr(addr), .rd_data(rd_data), .ack(ack), .err(err));

    task tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // access with a random gap, then data, ack and err compared
    task acc(input logic w, input logic [15:0] a, input logic [15:0] x, input logic ee);
        logic [15:0] d;
        logic e;
        logic k;
        dmsr_master_inst.access($unsigned($random(seed)) % 3, w, a, d, e, k);
        check(d, x);
        check({14'h0000, k, e}, {14'h0000, 1'b1, ee});
    endtask : acc

    // count events on consecutive cycles
    task pulse(input dmsr_evt_t v, input int cnt);
        repeat (cnt)
        begin
            @(posedge clk);
            #1 evt = v;
        end
        @(posedge clk);
        #1 evt = '0;
    endtask : pulse

    // expected status word
    function automatic logic [15:0] exp_stat(input dmsr_mon_t m);
        return {10'h000, m.alarm, m.output_on, m.fault ? 2'h2 : m.ready ? 2'h1 : 2'h0,
            m.dir_forward ? 2'h1 : m.dir_reverse ? 2'h2 : 2'h0};
    endfunction : exp_stat

    // expected word of a pass-through register
    function automatic logic [15:0] exp_word(input logic [15:0] a, input dmsr_mon_t m);
        case (a)
            16'h2211: return m.digital_output_state;
            16'h2212: return m.active_step_speed;
            16'h2213: return m.input_pin_state;
            16'h2214: return m.output_pin_state;
            16'h2216: return m.pulse_input_frequency;
            16'h2218: return m.position_tracking_error;
            16'h2219: return m.counter_overload_level;
            16'h221A: return m.ground_fault_level;
            16'h221B: return m.bus_voltage_ripple;
            16'h221C: return m.logic_controller_word;
            16'h221D: return m.magnet_motor_poles;
            16'h221E: return m.user_page_value;
            16'h221F: return m.selected_output_value;
            16'h2222: return m.fan_speed_percent;
            16'h2223: return {15'h0000, m.torque_mode};
            16'h2224: return m.switching_frequency;
            16'h2226: return exp_stat(m);
            16'h2227: return m.estimated_torque;
            16'h2228: return m.torque_setpoint;
            16'h2229: return m.energy_reading;
            16'h222E: return m.loop_reference;
            16'h222F: return m.loop_offset;
            16'h2230: return m.loop_output_frequency;
            16'h2231: return 16'h3C5A;
            16'h2232: return m.auxiliary_frequency;
            16'h2233: return m.primary_frequency;
            16'h2234: return m.combined_frequency;
            default: return 16'h0000;
        endcase
    endfunction : exp_word

    // watchdog at 90,000 cycles, the run needs about 68,000
    initial
    begin
        #900000;
        n_mismatch++;
        tally_and_finish;
    end

    initial
    begin
        mon = '0;
        evt = '0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        foreach (ca[i]) acc(1'b0, ca[i], 16'h0000, 1'b0);
        // random words and flags, stopped drive
        for (int r = 0; r < 16; r++)
        begin
            for (int j = 0; j < 24; j++) mon[j * 16 + 9 +: 16] = 16'($random(seed));
            mon[8:0] = {1'b0, 8'($random(seed))};
            foreach (wa[i]) acc(1'b0, wa[i], exp_word(wa[i], mon), 1'b0);
        end
        acc(1'b0, 16'h2210, 16'h0000, 1'b1);
        acc(1'b0, 16'h2235, 16'h0000, 1'b1);
        acc(1'b1, 16'h2212, 16'h0000, 1'b1);
        acc(1'b0, 16'h2212, mon.active_step_speed, 1'b0);
        // revolution and second encoder counts
        mon[8:0] = 9'h080;
        pulse(6'h30, 3);
        acc(1'b0, 16'h2215, 16'h0003, 1'b0);
        acc(1'b0, 16'h2217, 16'h0003, 1'b0);
        mon.dir_forward = 1'b0;
        mon.dir_reverse = 1'b1;
        acc(1'b0, 16'h2215, 16'h0000, 1'b0);
        pulse(6'h30, 65540);
        acc(1'b0, 16'h2215, 16'hFFFF, 1'b0);
        acc(1'b0, 16'h2217, 16'hFFFF, 1'b0);
        mon.stop_display_zero = 1'b1;
        acc(1'b0, 16'h2215, 16'h0000, 1'b0);
        acc(1'b0, 16'h2217, 16'hFFFF, 1'b0);
        mon.stop_display_zero = 1'b0;
        // terminal pulses and motor position below zero
        n = 1 + $unsigned($random(seed)) % 20;
        pulse(6'h08, n);
        acc(1'b0, 16'h222A, 16'(n), 1'b0);
        acc(1'b0, 16'h222B, 16'h0000, 1'b0);
        pulse(6'h01, 2);
        pulse(6'h03, 3);
        acc(1'b0, 16'h222C, 16'hFFFE, 1'b0);
        acc(1'b0, 16'h222D, 16'hFFFF, 1'b0);
        // turns and run position held when stopped
        mon.running = 1'b1;
        pulse(6'h06, n);
        mon.running = 1'b0;
        pulse(6'h06, 4);
        acc(1'b0, 16'h2220, 16'(n), 1'b0);
        acc(1'b0, 16'h2221, 16'(n), 1'b0);
        mon.running = 1'b1;
        acc(1'b0, 16'h2220, 16'h0000, 1'b0);
        acc(1'b0, 16'h2221, 16'h0000, 1'b0);
        tally_and_finish;
    end
endmodule : tb_top
